// [hw/obc_config_loader.v]
// Overview of operation
// - Boot swap exchanges primary byte 0080H with alternate 1080H.
// - Detector start option fixed under self-programming with boot swap; default mode kept.
// - Boot swap reads alternate detector option 1081H in place of 0081H, except under self-programming.
// - Watchdog keeps counting during self-programming and emulation.
// - Stoppable low-speed oscillator: no watchdog clock in HALT/STOP.
// - Auxiliary 8-bit timer keeps its clock in HALT and STOP.
// - Reset mode may toggle reset; software sets release delay.
// - Interrupt mode may raise frequent requests near threshold.
// - No reset if voltage is below level when mode bit set.
`timescale 1ns/1ps
`include "obc_defines.vh"
module obc_config_loader (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        boot_swap,
  input  wire        self_prog,
  input  wire        standby,
  input  wire        osc_halt_ctrl,
  input  wire        lowspeed_tick,
  input  wire        volt_below,
  output reg  [15:0] flash_addr_q,
  output reg         flash_rd_q,
  input  wire [7:0]  flash_rdata,
  input  wire [3:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata_q,
  output reg         load_done_q,
  output reg  [2:0]  wdt_clock_sel_q,
  output reg  [1:0]  wdt_open_period_q,
  output reg         lowspeed_osc_stoppable_q,
  output reg         detector_start_option_q,
  output reg         debug_en_q,
  output reg         opt_illegal_q,
  output reg         wdt_clk_en_q,
  output reg         aux_timer_clk_en_q,
  output reg         detector_reset_q,
  output reg         detector_irq_q
);
  localparam [4:0] ST_RD0  = 5'b00001;
  localparam [4:0] ST_RD1  = 5'b00010;
  localparam [4:0] ST_RD4  = 5'b00100;
  localparam [4:0] ST_DONE = 5'b01000;
  localparam [4:0] ST_WAIT = 5'b10000;

  reg  [4:0]  state_q;
  reg  [1:0]  wait_q;
  reg  [7:0]  opt0_q;
  reg  [7:0]  opt1_q;
  reg  [7:0]  opt4_q;
  reg         swap_q;
  reg         selfp_q;
  reg  [7:0]  delay_q;
  reg         reset_mode_q;
  reg         armed_q;
  reg         below_m_q;
  reg         below_q;
  reg         below_d1_q;
  reg         hold_q;
  wire        rel_busy;

  // Address of a byte in the set chosen by the swap strap
  function [15:0] opt_addr;
    input [15:0] pri;
    input [15:0] alt;
    input        swp;
    begin
      opt_addr = swp ? alt : pri;
    end
  endfunction

  // Supply comparator output crosses in from the analog side
  always @(posedge clk) begin
    if (!reset_n) begin
      below_m_q <= 1'b0;
      below_q   <= 1'b0;
    end else begin
      below_m_q <= volt_below;
      below_q   <= below_m_q;
    end
  end

  // Loader: one pass after reset release, values then frozen
  always @(posedge clk) begin
    if (!reset_n) begin
      state_q      <= ST_RD0;
      wait_q       <= 2'h0;
      flash_addr_q <= 16'h0000;
      flash_rd_q   <= 1'b0;
      opt0_q       <= `OBC_RST_BYTE;
      opt1_q       <= `OBC_RST_BYTE;
      opt4_q       <= `OBC_RST_BYTE;
      swap_q       <= 1'b0;
      selfp_q      <= 1'b0;
      load_done_q  <= 1'b0;
    end else begin
      flash_rd_q <= 1'b0;
      case (state_q)
        ST_RD0: begin
          swap_q       <= boot_swap;
          selfp_q      <= self_prog;
          // Swapped set read from the alternate location
          flash_addr_q <= opt_addr(`OBC_ADDR_OPT0, `OBC_ADDR_ALT0,
                                   boot_swap);
          flash_rd_q   <= 1'b1;
          wait_q       <= `OBC_READ_CYC;
          state_q      <= ST_WAIT;
        end
        ST_WAIT: begin
          if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
          end else if (flash_addr_q[7:0] == 8'h80) begin
            opt0_q       <= flash_rdata;
            flash_addr_q <= opt_addr(`OBC_ADDR_OPT1, `OBC_ADDR_ALT1,
                                     swap_q);
            flash_rd_q   <= 1'b1;
            wait_q       <= `OBC_READ_CYC;
            state_q      <= ST_RD1;
          end else begin
            opt4_q  <= flash_rdata;
            state_q <= ST_DONE;
          end
        end
        ST_RD1: begin
          if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
          end else begin
            // Self-programming swap keeps the default clear mode
            opt1_q       <= (selfp_q && swap_q) ? `OBC_RST_BYTE
                                                : flash_rdata;
            flash_addr_q <= opt_addr(`OBC_ADDR_OPT4, `OBC_ADDR_ALT4,
                                     swap_q);
            flash_rd_q   <= 1'b1;
            wait_q       <= `OBC_READ_CYC;
            state_q      <= ST_RD4;
          end
        end
        ST_RD4: begin
          if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
          end else begin
            opt4_q  <= flash_rdata;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          load_done_q <= 1'b1;
        end
        default: begin
          state_q <= ST_RD0;
        end
      endcase
    end
  end

  // Decoded settings, held from the frozen bytes
  always @(posedge clk) begin
    if (!reset_n) begin
      wdt_clock_sel_q          <= 3'h0;
      wdt_open_period_q        <= 2'h0;
      lowspeed_osc_stoppable_q <= 1'b0;
      detector_start_option_q  <= 1'b0;
      debug_en_q               <= 1'b0;
      opt_illegal_q            <= 1'b0;
    end else begin
      wdt_clock_sel_q          <= opt0_q[`OBC_WDCS_MSB:`OBC_WDCS_LSB];
      wdt_open_period_q        <= opt0_q[`OBC_WIN_MSB:`OBC_WIN_LSB];
      // Bit set means the oscillator cannot be stopped
      lowspeed_osc_stoppable_q <= ~opt0_q[`OBC_OSC_STOP_BIT];
      detector_start_option_q  <= opt1_q[0];
      debug_en_q  <= (opt4_q == `OBC_DBG_ON_A) ||
                     (opt4_q == `OBC_DBG_ON_B);
      // Flag the prohibited pair rather than alter it
      opt_illegal_q <= load_done_q &&
                       (opt0_q[`OBC_WDCS_MSB:`OBC_WDCS_LSB] == 3'h0) &&
                       (opt0_q[`OBC_WIN_MSB:`OBC_WIN_LSB] == 2'h0);
    end
  end

  // Count clock gating; self_prog does not stop the watchdog
  always @(posedge clk) begin
    if (!reset_n) begin
      wdt_clk_en_q       <= 1'b0;
      aux_timer_clk_en_q <= 1'b0;
    end else begin
      // Stoppable osc: gate in standby whatever halt ctrl says
      wdt_clk_en_q <= lowspeed_tick && load_done_q &&
                      !(lowspeed_osc_stoppable_q && standby) &&
                      !(osc_halt_ctrl && !standby &&
                        lowspeed_osc_stoppable_q);
      aux_timer_clk_en_q <= lowspeed_tick;
    end
  end

  // Software registers
  always @(posedge clk) begin
    if (!reset_n) begin
      delay_q      <= `OBC_RST_DELAY;
      reset_mode_q <= 1'b0;
      armed_q      <= 1'b0;
      rdata_q      <= 8'h00;
    end else begin
      // Arming checks level first: no reset if already low
      armed_q <= reset_mode_q && (armed_q || !below_q);
      if (wr && addr == `OBC_REG_CTRL) begin
        reset_mode_q <= wdata[0];
        armed_q      <= 1'b0;
      end
      if (wr && addr == `OBC_REG_DELAY) begin
        delay_q <= wdata;
      end
      rdata_q <= 8'h00;
      if (rd) begin
        case (addr)
          `OBC_REG_OPT0:   rdata_q <= opt0_q;
          `OBC_REG_OPT1:   rdata_q <= opt1_q;
          `OBC_REG_OPT4:   rdata_q <= opt4_q;
          `OBC_REG_STATUS: rdata_q <= {3'h0, opt_illegal_q, swap_q,
                                       debug_en_q, below_q, load_done_q};
          `OBC_REG_CTRL:   rdata_q <= {7'h00, reset_mode_q};
          `OBC_REG_DELAY:  rdata_q <= delay_q;
          default:         rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Release delay timer, restarted when the supply recovers
  // Only an armed detector starts it, so no late reset on a good supply
  obc_release_timer u_rel (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (below_d1_q && !below_q && armed_q),
    .delay   (delay_q),
    .busy_q  (rel_busy)
  );

  // Detector outputs: reset may repeat, interrupt may chatter
  always @(posedge clk) begin
    if (!reset_n) begin
      below_d1_q       <= 1'b0;
      hold_q           <= 1'b0;
      detector_reset_q <= 1'b0;
      detector_irq_q   <= 1'b0;
    end else begin
      below_d1_q <= below_q;
      hold_q     <= armed_q && below_q;
      // Hold bridges the cycle before the timer shows busy, no glitch
      detector_reset_q <= (armed_q && below_q) || hold_q ||
                          (rel_busy && reset_mode_q);
      // One pulse per falling crossing, reported only while reset mode is clear
      detector_irq_q <= !reset_mode_q && below_q && !below_d1_q;
    end
  end
endmodule

// [hw/obc_defines.vh]
`ifndef OBC_DEFINES_VH
`define OBC_DEFINES_VH
// Option byte addresses (primary set and alternate set)
`define OBC_ADDR_OPT0      16'h0080
`define OBC_ADDR_OPT1      16'h0081
`define OBC_ADDR_OPT2      16'h0082
`define OBC_ADDR_OPT3      16'h0083
`define OBC_ADDR_OPT4      16'h0084
`define OBC_ADDR_ALT0      16'h1080
`define OBC_ADDR_ALT1      16'h1081
`define OBC_ADDR_ALT4      16'h1084
// Software register offsets
`define OBC_REG_OPT0       4'h0
`define OBC_REG_OPT1       4'h1
`define OBC_REG_OPT4       4'h2
`define OBC_REG_STATUS     4'h3
`define OBC_REG_CTRL       4'h4
`define OBC_REG_DELAY      4'h5
// Field positions in option byte 0
`define OBC_WDCS_LSB       1
`define OBC_WDCS_MSB       3
`define OBC_WIN_LSB        5
`define OBC_WIN_MSB        6
`define OBC_OSC_STOP_BIT   4
// Debug enable codes
`define OBC_DBG_ON_A       8'h02
`define OBC_DBG_ON_B       8'h03
// Reset values
`define OBC_RST_BYTE       8'h00
`define OBC_RST_DELAY      8'h10
// Loader timing: cycles per flash read
`define OBC_READ_CYC       2'h2
`endif

// [hw/obc_release_timer.v]
`timescale 1ns/1ps
`include "obc_defines.vh"
// Counts a software-set delay after the detector lets go of reset
module obc_release_timer (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       start,
  input  wire [7:0] delay,
  output reg        busy_q
);
  reg [7:0] cnt_q;

  // Restart on every release, so a wobbling supply keeps it held
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= delay;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == 8'h00) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

// [testbench/obc_config_loader_properties.sv]
`timescale 1ns/1ps
module obc_config_loader_chk (
  input logic        clk,
  input logic        reset_n,
  input logic        rd,
  input logic        boot_swap,
  input logic        standby,
  input logic        osc_halt_ctrl,
  input logic        lowspeed_tick,
  input logic        volt_below,
  input logic [15:0] flash_addr_q,
  input logic        flash_rd_q,
  input logic [7:0]  rdata_q,
  input logic        load_done_q,
  input logic [2:0]  wdt_clock_sel_q,
  input logic [1:0]  wdt_open_period_q,
  input logic        lowspeed_osc_stoppable_q,
  input logic        detector_start_option_q,
  input logic        debug_en_q,
  input logic        opt_illegal_q,
  input logic        wdt_clk_en_q,
  input logic        aux_timer_clk_en_q,
  input logic        detector_reset_q,
  input logic        detector_irq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(rd) |-> rdata_q == 8'h00)
    else $error("read data not idle");
  a_swap_addr: assert property (flash_rd_q |->
    flash_addr_q[15:8] == (boot_swap ? 8'h10 : 8'h00))
    else $error("wrong option set read");
  a_illegal_flag: assert property (load_done_q && $past(load_done_q) |->
    opt_illegal_q == (wdt_clock_sel_q == 3'h0 &&
    wdt_open_period_q == 2'h0)) else $error("illegal flag wrong");
  a_opt_hold: assert property ($past(load_done_q, 2) |->
    $stable(wdt_clock_sel_q) && $stable(debug_en_q) &&
    $stable(detector_start_option_q)) else $error("options moved");
  a_done_sticky: assert property (load_done_q |=> load_done_q)
    else $error("load done dropped");
  a_wdt_gate: assert property (standby && lowspeed_osc_stoppable_q
    |=> !wdt_clk_en_q) else $error("watchdog clocked in standby");
  a_wdt_run: assert property (lowspeed_tick && !standby &&
    !osc_halt_ctrl && load_done_q |=> wdt_clk_en_q)
    else $error("watchdog tick lost");
  a_wdt_cause: assert property (wdt_clk_en_q |-> $past(lowspeed_tick))
    else $error("watchdog tick without cause");
  a_aux_tick: assert property ($past(reset_n) |->
    aux_timer_clk_en_q == $past(lowspeed_tick))
    else $error("aux tick wrong");
  a_irq_pulse: assert property (detector_irq_q |=> !detector_irq_q)
    else $error("irq too long");
  a_no_reset: assert property (!volt_below [*5] ##0
    !detector_reset_q |=> !detector_reset_q)
    else $error("reset with supply good");
endmodule
bind obc_config_loader obc_config_loader_chk chk_u (.*);

// [testbench/obc_flash_model.sv]
`timescale 1ns/1ps
// Flash holding both option sets; data held 3 cycles per read
module obc_flash_model (
  input  logic        clk,
  input  logic [15:0] flash_addr_q,
  input  logic        flash_rd_q,
  input  logic [47:0] image,
  output logic [7:0]  flash_rdata
);
  logic [7:0] byte_q = 8'h00;
  logic [1:0] hold_q = 2'h0;
  // Image is {alt4, alt1, alt0, pri4, pri1, pri0}
  always @(posedge clk) begin
    if (flash_rd_q) begin
      hold_q <= 2'h3;
      case (flash_addr_q)
        16'h0080: byte_q <= image[7:0];
        16'h0081: byte_q <= image[15:8];
        16'h0084: byte_q <= image[23:16];
        16'h1080: byte_q <= image[31:24];
        16'h1081: byte_q <= image[39:32];
        16'h1084: byte_q <= image[47:40];
        default:  byte_q <= 8'h00; // Reserved bytes kept 00
      endcase
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  // Past the hold time the bus shows garbage, not the last byte
  assign flash_rdata = (hold_q != 2'h0) ? byte_q : ~byte_q;
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, reset_n = 0, boot_swap = 0, self_prog = 0, standby = 0;
  logic osc_halt_ctrl = 0, lowspeed_tick = 0, volt_below = 0;
  logic wr = 0, rd = 0, flash_rd_q, load_done_q, lowspeed_osc_stoppable_q;
  logic detector_start_option_q, debug_en_q, opt_illegal_q, wdt_clk_en_q;
  logic aux_timer_clk_en_q, detector_reset_q, detector_irq_q;
  logic [3:0]  addr = 0;
  logic [7:0]  wdata = 0, flash_rdata, rdata_q;
  logic [15:0] flash_addr_q;
  logic [2:0]  wdt_clock_sel_q;
  logic [1:0]  wdt_open_period_q;
  logic [47:0] image = 0;
  int          fails = 0, checks = 0, i, k, w, a;
  // Rows: image {a4,a1,a0,p4,p1,p0}, {swap,self}, fields, status
  logic [47:0] img [4] = '{48'h0201_6E02_016E, 48'h0301_1002_016E,
                           48'h0001_3202_016E, 48'h0201_6E04_0040};
  logic [1:0]  mode [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
  logic [8:0]  exp [4] = '{9'h1fe, 9'h007, 9'h050, 9'h028};
  logic [7:0]  stat [4] = '{8'h05, 8'h1d, 8'h09, 8'h01};
  obc_config_loader dut_u (.*);
  obc_flash_model fm_u (.*);
  initial forever #2.5 clk = ~clk;
  // Low-speed tick every fourth cycle
  always begin
    repeat (3) @(posedge clk);
    lowspeed_tick <= 1;
    @(posedge clk);
    lowspeed_tick <= 0;
  end
  task chk(input string n, input logic [8:0] e, input logic [8:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd_chk(input logic [3:0] ad, input logic [7:0] e);
    @(posedge clk);
    addr <= ad; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", {1'b0, e}, {1'b0, rdata_q});
  endtask
  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000 fails++;
    test_done;
  end
  initial begin
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      reset_n <= 0; image <= img[i];
      {boot_swap, self_prog} <= mode[i];
      repeat (3) @(posedge clk);
      reset_n <= 1;
      for (k = 0; k < 40 && load_done_q !== 1'b1; k++) @(posedge clk);
      @(posedge clk);
      #1 chk("fields", exp[i], {wdt_clock_sel_q, wdt_open_period_q,
        lowspeed_osc_stoppable_q, detector_start_option_q, debug_en_q,
        opt_illegal_q});
      rd_chk(4'h3, stat[i]);
      $display("row %0d done", i);
    end
    // Read-only offset ignores writes; unmapped reads give zero
    wr_reg(4'h0, 8'hFF);
    rd_chk(4'h0, 8'h40);
    rd_chk(4'hF, 8'h00);
    $display("register done");
    // Standby with stop bit clear: only the aux timer keeps ticking
    @(posedge clk);
    standby <= 1; osc_halt_ctrl <= 0;
    w = 0; a = 0;
    repeat (40) begin
      @(posedge clk);
      #1 w += wdt_clk_en_q; a += aux_timer_clk_en_q;
    end
    chk("wdt ticks", 0, w);
    chk("aux ticks", 10, a);
    @(posedge clk);
    standby <= 0; osc_halt_ctrl <= 0;
    $display("standby done");
    // Interrupt mode: one short pulse per drop
    volt_below <= 1;
    w = 0;
    repeat (10) begin
      @(posedge clk);
      #1 w += detector_irq_q;
    end
    chk("irq pulses", 1, w);
    @(posedge clk);
    volt_below <= 0;
    // Reset mode: no reset on good supply, then reset and release
    wr_reg(4'h5, 8'h04);
    wr_reg(4'h4, 8'h01);
    repeat (8) @(posedge clk);
    #1 chk("reset good", 0, detector_reset_q);
    @(posedge clk);
    volt_below <= 1;
    repeat (8) @(posedge clk);
    #1 chk("reset low", 1, detector_reset_q);
    @(posedge clk);
    volt_below <= 0;
    for (k = 0; k < 30 && detector_reset_q !== 1'b0; k++) @(posedge clk);
    // Two sync flops, start, delay 4 plus one count, output flop, loop lag
    chk("release", 1, k == 10);
    $display("detector done");
    test_done;
  end
endmodule
